/* logic/i2cm_master_control.sv */
`include "i2cm_params.svh"
// Summary of operation
// - writing one to proceed advances the master to its next bus operation when pending without begin- or end-condition; otherwise it is dropped
// - writing one to begin-condition issues a Start at once when idle, or when pending without end-condition; otherwise it is dropped
// - writing one to end-condition issues a Stop when pending, after a NACK when a received byte is unacknowledged; otherwise it is dropped
// - proceed, begin and end are write-only; writing zero does nothing
// - with DMA enabled the master raises DMA requests for data operations
// - with DMA disabled no DMA request is ever raised
// - with DMA enabled in receive mode the master acknowledges bytes by itself
// - DMA enable reads back the last value written and resets to zero
module i2cm_master_control
  import i2cm_pkg::*;
#(
  parameter int QUARTER = `I2CM_QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [`I2CM_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`I2CM_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire i2cm_dma_t dma_i,
  output logic dma_req_o,
  output logic master_awaiting_service_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic scl_s;
  logic sda_s;
  i2cm_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({scl_i, sda_i}),
    .sync_o({scl_s, sda_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  logic aw_held, w_held, bvalid, rvalid, dma_en;
  logic [`I2CM_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data, rdata;
  logic [3:0] w_strb;
  logic [1:0] bresp, rresp;
  logic [7:0] tx_data;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_dma_en;
  logic [`I2CM_ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [7:0] next_tx_data;
  logic do_write, cmd_we;
  i2cm_cmd_t cmd;
  i2cm_state_t state;
  logic [7:0] rx_data;
  logic rx_mode, nack_seen;

  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o = !w_held && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign cmd_we = do_write && aw_addr == `I2CM_CMD_OFF && w_strb[0];
  assign cmd = i2cm_cmd_t'(w_data[3:0]);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_dma_en = dma_en;
    next_tx_data = tx_data;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `I2CM_RESP_OKAY;
      if (cmd_we) begin
        next_dma_en = cmd.dma_enable;
      end else if (aw_addr == `I2CM_DATA_OFF) begin
        if (w_strb[0]) begin
          next_tx_data = w_data[7:0];
        end
      end else if (aw_addr != `I2CM_CMD_OFF && aw_addr != `I2CM_STAT_OFF) begin
        next_bresp = `I2CM_RESP_SLVERR;
      end
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = `I2CM_RESP_OKAY;
      next_rdata = 32'h0;
      case (s_axi_araddr_i)
        // strobe bits keep no state and read zero
        `I2CM_CMD_OFF: next_rdata[`I2CM_DMA_BIT] = dma_en;
        `I2CM_DATA_OFF: next_rdata[7:0] = rx_data;
        `I2CM_STAT_OFF: next_rdata[3:0] = {nack_seen, rx_mode, dma_req_o, master_awaiting_service_o};
        default: next_rresp = `I2CM_RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `I2CM_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `I2CM_RESP_OKAY;
      dma_en <= 1'b0;
      tx_data <= 8'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      dma_en <= next_dma_en;
      tx_data <= next_tx_data;
    end
  end
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  ////////////////////////////////////////////////////////////////////////////
  // bus engine: four quarter phases per bit, scl released in phases 2 and 3
  i2cm_state_t next_state;
  logic [1:0] phase, next_phase;
  logic [15:0] qcnt, next_qcnt;
  logic [3:0] bit_idx, next_bit_idx;
  logic [7:0] shift, next_shift, next_rx_data;
  logic next_rx_mode, addr_phase, next_addr_phase, send_nack, next_send_nack;
  logic ack_owed, next_ack_owed, next_nack_seen;
  logic scl_low, next_scl_low, sda_low, next_sda_low;
  logic tick;

  // stretching: the first high quarter (phase 2) does not end until the line is seen high
  assign tick = qcnt == 16'(QUARTER - 1) && !(phase == `I2CM_SAMPLE_PHASE && !scl_s);

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_qcnt = qcnt;
    next_bit_idx = bit_idx;
    next_shift = shift;
    next_rx_data = rx_data;
    next_rx_mode = rx_mode;
    next_addr_phase = addr_phase;
    next_send_nack = send_nack;
    next_ack_owed = ack_owed;
    next_nack_seen = nack_seen;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    if (state == I2CM_START || state == I2CM_BIT || state == I2CM_STOP) begin
      next_qcnt = tick ? 16'h0 : (qcnt == 16'(QUARTER - 1) ? qcnt : qcnt + 16'h1);
      next_phase = tick ? phase + 2'h1 : phase;
      next_scl_low = !tick ? scl_low : phase[0] == 1'b1 ? (phase == 2'h3) : scl_low;
      if (tick && phase == 2'h1) begin
        next_scl_low = 1'b0;
      end
      if (tick && phase == `I2CM_LAST_PHASE) begin
        next_scl_low = state != I2CM_STOP;
      end
    end
    case (state)
      I2CM_IDLE, I2CM_PEND: begin
        if (cmd_we && cmd.end_condition && state == I2CM_PEND) begin
          next_phase = 2'h0;
          if (ack_owed) begin
            next_state = I2CM_BIT;
            next_bit_idx = `I2CM_ACK_IDX;
            next_send_nack = 1'b1;
          end else begin
            next_state = I2CM_STOP;
          end
        end else if (cmd_we && cmd.begin_condition) begin
          next_state = I2CM_START;
          next_phase = 2'h0;
        end else if (cmd_we && cmd.proceed && state == I2CM_PEND) begin
          next_state = I2CM_BIT;
          next_phase = 2'h0;
          next_send_nack = 1'b0;
          next_bit_idx = ack_owed ? `I2CM_ACK_IDX : 4'h0;
          next_shift = tx_data;
        end else if (state == I2CM_PEND && dma_en && !cmd_we) begin
          // a write in flight decides first, so a zero write keeps pending
          next_state = I2CM_DMA;
        end
      end
      I2CM_START: begin
        if (tick) begin
          case (phase)
            2'h0: next_sda_low = 1'b0;
            2'h2: next_sda_low = 1'b1;
            default: next_sda_low = sda_low;
          endcase
          if (phase == `I2CM_LAST_PHASE) begin
            next_state = I2CM_BIT;
            next_bit_idx = 4'h0;
            next_shift = tx_data;
            next_addr_phase = 1'b1;
            next_rx_mode = 1'b0;
            next_ack_owed = 1'b0;
          end
        end
      end
      I2CM_BIT: begin
        if (tick && phase == 2'h0) begin
          if (bit_idx == `I2CM_ACK_IDX) begin
            next_sda_low = rx_mode && !send_nack;
          end else begin
            next_sda_low = !rx_mode && !shift[7];
          end
        end
        if (tick && phase == `I2CM_SAMPLE_PHASE) begin
          if (bit_idx == `I2CM_ACK_IDX) begin
            next_nack_seen = rx_mode ? nack_seen : sda_s;
          end else begin
            next_shift = {shift[6:0], sda_s};
          end
        end
        if (tick && phase == `I2CM_LAST_PHASE) begin
          next_bit_idx = bit_idx + 4'h1;
          if (bit_idx == `I2CM_ACK_IDX) begin
            // sda is let go a quarter later: releasing it as scl falls races into a false stop
            next_ack_owed = 1'b0;
            if (rx_mode) begin
              next_bit_idx = 4'h0;
              next_state = send_nack ? I2CM_STOP : I2CM_BIT;
            end else if (addr_phase) begin
              next_addr_phase = 1'b0;
              next_rx_mode = tx_data[0];
              next_state = I2CM_PEND;
            end else begin
              next_state = dma_en ? I2CM_DMA : I2CM_PEND;
            end
          end else if (bit_idx == `I2CM_LAST_IDX && rx_mode) begin
            next_rx_data = shift;
            next_ack_owed = 1'b1;
            next_state = dma_en ? I2CM_DMA : I2CM_PEND;
          end
        end
      end
      I2CM_DMA: begin
        if (!dma_en) begin
          next_state = I2CM_PEND;
        end else if (dma_i.done) begin
          next_state = I2CM_BIT;
          next_phase = 2'h0;
          next_send_nack = 1'b0;
          next_bit_idx = ack_owed ? `I2CM_ACK_IDX : 4'h0;
          next_shift = rx_mode ? shift : dma_i.wdata;
        end
      end
      I2CM_STOP: begin
        if (tick && phase == 2'h0) begin
          next_sda_low = 1'b1;
        end
        if (tick && phase == `I2CM_LAST_PHASE) begin
          next_sda_low = 1'b0;
          next_state = I2CM_IDLE;
        end
      end
      default: next_state = I2CM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= I2CM_IDLE;
      phase <= 2'h0;
      qcnt <= 16'h0;
      bit_idx <= 4'h0;
      shift <= 8'h0;
      rx_data <= 8'h0;
      rx_mode <= 1'b0;
      addr_phase <= 1'b0;
      send_nack <= 1'b0;
      ack_owed <= 1'b0;
      nack_seen <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      qcnt <= next_qcnt;
      bit_idx <= next_bit_idx;
      shift <= next_shift;
      rx_data <= next_rx_data;
      rx_mode <= next_rx_mode;
      addr_phase <= next_addr_phase;
      send_nack <= next_send_nack;
      ack_owed <= next_ack_owed;
      nack_seen <= next_nack_seen;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
    end
  end

  assign scl_o = 1'b0;
  assign scl_oe_o = scl_low;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low;
  assign dma_req_o = state == I2CM_DMA && dma_en;
  assign master_awaiting_service_o = state == I2CM_IDLE || state == I2CM_PEND;

  ////////////////////////////////////////////////////////////////////////////
  a_dma_req_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !dma_en && state != I2CM_DMA |=> !dma_req_o) else $error("dma request while dma disabled");
  a_dma_req_raised: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == I2CM_PEND && dma_en && !cmd_we |=> dma_req_o) else $error("dma request missing");
  a_proceed_advances: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_we && state == I2CM_PEND && cmd == 4'h1 |=> state == I2CM_BIT && phase == 2'h0)
    else $error("proceed did not advance");
  a_zero_no_effect: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_we && state == I2CM_PEND && cmd[2:0] == 3'h0 |=> state == I2CM_PEND)
    else $error("zero command changed state");
  a_begin_starts: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_we && state == I2CM_IDLE && cmd.begin_condition |=> state == I2CM_START)
    else $error("begin did not start");
  a_stop_nack_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_we && state == I2CM_PEND && ack_owed && cmd.end_condition
    |=> state == I2CM_BIT && send_nack && bit_idx == `I2CM_ACK_IDX)
    else $error("stop without nack while receiving");
  a_auto_ack: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == I2CM_DMA && dma_en && rx_mode && ack_owed && dma_i.done
    |=> state == I2CM_BIT && bit_idx == `I2CM_ACK_IDX && !send_nack ##[1:200] sda_oe_o)
    else $error("no automatic ack");
  a_dma_readback: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_we |=> dma_en == $past(w_data[`I2CM_DMA_BIT]))
    else $error("dma enable not stored");
endmodule : i2cm_master_control

/* logic/i2cm_params.svh */
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH
`define I2CM_ADDR_W 8
`define I2CM_CMD_OFF 8'h20
`define I2CM_DATA_OFF 8'h28
`define I2CM_STAT_OFF 8'h2c
`define I2CM_PROCEED_BIT 0
`define I2CM_BEGIN_BIT 1
`define I2CM_END_BIT 2
`define I2CM_DMA_BIT 3
`define I2CM_RESP_OKAY 2'b00
`define I2CM_RESP_SLVERR 2'b10
`define I2CM_CLK_NS 25
`define I2CM_QUARTER_NS 625
`define I2CM_QUARTER_CYC ((`I2CM_QUARTER_NS + `I2CM_CLK_NS - 1) / `I2CM_CLK_NS)
`define I2CM_ACK_IDX 4'h8
`define I2CM_LAST_IDX 4'h7
`define I2CM_LAST_PHASE 2'h3
`define I2CM_SAMPLE_PHASE 2'h2
`endif

/* logic/i2cm_pkg.sv */
package i2cm_pkg;
  typedef struct packed {
    logic dma_enable;
    logic end_condition;
    logic begin_condition;
    logic proceed;
  } i2cm_cmd_t;
  typedef struct packed {
    logic done;
    logic [7:0] wdata;
  } i2cm_dma_t;
  typedef enum logic [2:0] {
    I2CM_IDLE,
    I2CM_PEND,
    I2CM_START,
    I2CM_BIT,
    I2CM_DMA,
    I2CM_STOP
  } i2cm_state_t;
endpackage : i2cm_pkg

/* logic/i2cm_sync.sv */
module i2cm_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // released bus lines idle high
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage1[g] <= 1'b1;
          stage2[g] <= 1'b1;
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate
  assign sync_o = stage2;
endmodule : i2cm_sync

/* verification/i2cm_slave_model.sv */
module i2cm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2d
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic [15:0] stretch_ns_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic [7:0] rx_byte_o,
  output logic ack_seen_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  logic [7:0] sh;
  logic sel, rd, addr_ph, tx_on, ack_due;
  initial begin
    {scl_oe_o, sda_oe_o, sel, rd, addr_ph, tx_on, ack_due, ack_seen_o} = '0;
    cnt = 0;
    sh = '0;
    rx_byte_o = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // start or repeated start re-arms the address phase
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    cnt = 0;
    addr_ph = 1'b1;
    sel = 1'b0;
    tx_on = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    sel = 1'b0;
    tx_on = 1'b0;
  end
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (ack_due) begin
      ack_seen_o = !sda_i;
      tx_on = !sda_i;
      ack_due = 1'b0;
    end
    cnt = cnt + 1;
  end
  // sda is set up before the clock is stretched, never while scl is high
  always @(negedge scl_i) begin
    sda_oe_o = 1'b0;
    if (cnt == 9) cnt = 0;
    if (cnt == 8 && addr_ph) begin
      addr_ph = 1'b0;
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      tx_on = sel && sh[0];
      sda_oe_o = sel;
    end else if (cnt == 8 && sel && !rd) begin
      rx_byte_o = sh;
      sda_oe_o = 1'b1;
    end else if (cnt < 8 && tx_on) begin
      sda_oe_o = !tx_byte_i[7 - cnt];
      ack_due = 1'b1;
    end
    if (stretch_ns_i != 16'h0) begin // slow slave holds the clock low
      scl_oe_o = 1'b1;
      #(stretch_ns_i);
      scl_oe_o = 1'b0;
    end
  end
endmodule : i2cm_slave_model

/* verification/i2c_master_control_tb_top.sv */
`include "i2cm_params.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module i2c_master_control_tb_top
  import i2cm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = 7'h2d;
  localparam logic [7:0] CMD = `I2CM_CMD_OFF;
  localparam logic [7:0] DAT = `I2CM_DATA_OFF;
  localparam logic [7:0] STA = `I2CM_STAT_OFF;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, dma_req, awaiting;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic scl_oe, sda_oe, slv_scl_oe, slv_sda_oe, slv_ack;
  wire logic scl = !(scl_oe === 1'b1 || slv_scl_oe === 1'b1);
  wire logic sda = !(sda_oe === 1'b1 || slv_sda_oe === 1'b1);
  i2cm_dma_t dma = '0;
  logic [7:0] slv_tx = '0, slv_rx, byte_v;
  logic [15:0] stretch = '0;
  logic dma_on = 1'b0;
  int checks = 0, fail_count = 0, seed = 32'h744b800d;
  logic [65:0] rq[$];
  logic [1:0] wq[$];
  always #12.5 clk = !clk;
  i2cm_master_control #(.QUARTER(2)) i_dut (.clk_i(clk), .reset_n_i(reset_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .dma_i(dma), .dma_req_o(dma_req), .master_awaiting_service_o(awaiting));
  i2cm_slave_model #(.ADDR(ADDR)) i_slave (.scl_i(scl), .sda_i(sda), .tx_byte_i(slv_tx),
    .stretch_ns_i(stretch), .scl_oe_o(slv_scl_oe), .sda_oe_o(slv_sda_oe), .rx_byte_o(slv_rx),
    .ack_seen_o(slv_ack));
  //////////////////////////////////////////////////////////////////////////////
  // negedge sampling sees what the next rising edge will take
  always @(negedge clk) begin
    logic [65:0] e;
    logic [1:0] b;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = rq.pop_front();
      `CHK("rdata", e[31:0] & e[63:32], rdata & e[63:32])
      `CHK("rresp", e[65:64], rresp)
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      b = wq.pop_front();
      `CHK("bresp", b, bresp)
    end
    if (dma_req !== 1'b0) `CHK("dma_req_enabled", 1'b1, dma_on)
  end
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, wh, bh;
    wq.push_back(r);
    if (a == CMD && d[3]) dma_on = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (a == CMD && !d[3]) dma_on = 1'b0;
    // one edge between calls, so no signal is lowered and raised in one step
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
    logic h;
    rq.push_back({r, m, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    h = 1'b0;
    while (!h) begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge clk);
      h = rvalid;
      @(posedge clk);
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  // only after a command that leaves the idle or pending state
  task automatic wait_svc;
    do @(negedge clk); while (awaiting === 1'b1);
    do @(negedge clk); while (awaiting !== 1'b1);
    @(posedge clk);
  endtask : wait_svc
  task automatic wait_dma;
    do @(negedge clk); while (dma_req !== 1'b1);
    @(posedge clk);
  endtask : wait_dma
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(CMD, 32'hf, 32'h0, `I2CM_RESP_OKAY);
    rd(STA, 32'h1, 32'h1, `I2CM_RESP_OKAY);
    rd(8'h3c, 32'h0, 32'h0, `I2CM_RESP_SLVERR);
    wr(8'h3c, 32'h0, `I2CM_RESP_SLVERR);
    wr(CMD, 32'h8, `I2CM_RESP_OKAY);
    rd(CMD, 32'hf, 32'h8, `I2CM_RESP_OKAY);
    wr(CMD, 32'h0, `I2CM_RESP_OKAY);
    rd(CMD, 32'hf, 32'h0, `I2CM_RESP_OKAY);
    wr(DAT, {24'h0, ADDR, 1'b0}, `I2CM_RESP_OKAY);
    wr(CMD, 32'h2, `I2CM_RESP_OKAY);
    wait_svc();
    rd(STA, 32'h8, 32'h0, `I2CM_RESP_OKAY);
    byte_v = 8'($random(seed));
    wr(DAT, {24'h0, byte_v}, `I2CM_RESP_OKAY);
    stretch <= 16'd300;
    wr(CMD, 32'h1, `I2CM_RESP_OKAY);
    wait_svc();
    `CHK("slave_rx", byte_v, slv_rx)
    stretch <= 16'd0;
    wr(CMD, 32'h0, `I2CM_RESP_OKAY);
    rd(STA, 32'h1, 32'h1, `I2CM_RESP_OKAY);
    // repeated start into a read of two bytes
    byte_v = 8'($random(seed));
    slv_tx <= byte_v;
    wr(DAT, {24'h0, ADDR, 1'b1}, `I2CM_RESP_OKAY);
    wr(CMD, 32'h2, `I2CM_RESP_OKAY);
    wait_svc();
    wr(CMD, 32'h1, `I2CM_RESP_OKAY);
    wait_svc();
    rd(DAT, 32'hff, {24'h0, byte_v}, `I2CM_RESP_OKAY);
    wr(CMD, 32'h1, `I2CM_RESP_OKAY);
    wait_svc();
    `CHK("master_ack", 1'b1, slv_ack)
    wr(CMD, 32'h4, `I2CM_RESP_OKAY);
    wait_svc();
    `CHK("master_nack", 1'b0, slv_ack)
    `CHK("scl_idle", 1'b1, scl)
    `CHK("sda_idle", 1'b1, sda)
    // data byte handed over by dma
    wr(DAT, {24'h0, ADDR, 1'b0}, `I2CM_RESP_OKAY);
    wr(CMD, 32'h2, `I2CM_RESP_OKAY);
    wait_svc();
    wr(CMD, 32'h8, `I2CM_RESP_OKAY);
    wait_dma();
    byte_v = 8'($random(seed));
    dma <= '{done: 1'b1, wdata: byte_v};
    @(posedge clk);
    dma <= '0;
    wait_dma();
    `CHK("dma_slave_rx", byte_v, slv_rx)
    wr(CMD, 32'h0, `I2CM_RESP_OKAY);
    wr(CMD, 32'h4, `I2CM_RESP_OKAY);
    wait_svc();
    // receive by dma: the master acknowledges on its own
    byte_v = 8'($random(seed));
    slv_tx <= byte_v;
    wr(DAT, {24'h0, ADDR, 1'b1}, `I2CM_RESP_OKAY);
    wr(CMD, 32'h2, `I2CM_RESP_OKAY);
    wait_svc();
    wr(CMD, 32'h9, `I2CM_RESP_OKAY);
    wait_dma();
    rd(DAT, 32'hff, {24'h0, byte_v}, `I2CM_RESP_OKAY);
    dma <= '{done: 1'b1, wdata: 8'h0};
    @(posedge clk);
    dma <= '0;
    wait_dma();
    `CHK("dma_auto_ack", 1'b1, slv_ack)
    wr(CMD, 32'h0, `I2CM_RESP_OKAY);
    wr(CMD, 32'h4, `I2CM_RESP_OKAY);
    wait_svc();
    `CHK("dma_rx_nack", 1'b0, slv_ack)
    // nobody answers this address
    wr(DAT, {24'h0, ADDR ^ 7'h1, 1'b0}, `I2CM_RESP_OKAY);
    wr(CMD, 32'h2, `I2CM_RESP_OKAY);
    wait_svc();
    rd(STA, 32'h8, 32'h8, `I2CM_RESP_OKAY);
    wr(CMD, 32'h4, `I2CM_RESP_OKAY);
    wait_svc();
    `CHK("sda_released", 1'b1, sda)
    stop_test();
  end
endmodule : i2c_master_control_tb_top
